// ---- rtl/rpf_defines.vh ----
// Constants for the receive frame flag block: register map, field
// positions, reset values and widths.
// Assumes inclusion by bare name from the design files of this block.
`ifndef RPF_DEFINES_VH
`define RPF_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define RPF_OFS_IF_CONFIG      8'h00
`define RPF_OFS_CHANNEL_CONFIG 8'h04
`define RPF_OFS_MIN_LENGTH     8'h08
`define RPF_OFS_MAX_LENGTH     8'h0c
`define RPF_OFS_STATUS         8'h10
`define RPF_OFS_BAD_COUNT      8'h14

// ****************************************************************
// Field positions of rx_if_config
// ****************************************************************
`define RPF_BIT_POS_MODE       0
`define RPF_BIT_TEST_OEN       1
`define RPF_BIT_FCS_REPORT     2
`define RPF_BIT_SHORT_CHECK    3
`define RPF_BIT_LONG_CHECK     4
`define RPF_IF_CONFIG_W        5

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define RPF_RST_IF_CONFIG      5'h01
`define RPF_RST_CHANNEL_CONFIG 4'h0
`define RPF_RST_MIN_LENGTH     16'h0000
`define RPF_RST_MAX_LENGTH     16'hffff
`define RPF_LEN_W              16
`define RPF_CHANNELS           4
`define RPF_BYTES_PER_WORD     3'h4

// ****************************************************************
// AXI response codes
// ****************************************************************
`define RPF_RESP_OKAY          2'b00
`define RPF_RESP_SLVERR        2'b10

`endif

// ---- rtl/rpf_sync_edge.v ----
// Two-stage synchroniser for a level from another domain, with a
// rising-edge pulse taken from the second and third stages.
// Assumes the input toggles no faster than every two clock periods.
`timescale 1ns/1ps

module rpf_sync_edge (
  input  wire clk,
  input  wire reset_n,
  input  wire async_in,
  output wire level,
  output wire rise
);

  reg meta_q;
  reg sync_q;
  reg prev_q;

  // Only sync_q reads meta_q; edge logic looks at later stages
  always @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule

// ---- rtl/rpf_rx_flags.v ----
// Receive output flags of a cell/packet interface: start, end, parity
// and packet-error marks beside each word read from the channel FIFOs,
// with an AXI4-Lite register file for configuration and status.
// Assumes the FIFO read side runs on CLK and presents one word at a
// time; the link clock and read enable arrive as asynchronous pins.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rpf_defines.vh"

// What this block does
// - Raise start flag on first word, end flag on last word.
// - First frame byte leaves on the most significant byte lane.
// - Start and parity flags float or drive exactly as the data bus does.
// - End flag only in packet mode; floats in cell mode unless test enabled.
// - Parity over the data word; per-channel odd or even choice.
// - Error flag only in packet mode; floats in cell mode unless test enabled.
// - Error flag only on the last word, together with the end flag.
// - Packet ending in an abort sequence is errored.
// - Check-sequence error counts only while its report enable is set.
// - Packet shorter than minimum length is errored when that check is enabled.
// - Packet longer than maximum length is errored when that check is enabled.
// - FIFO overflow marked on the last word flags that word errored.
// - All flags change on the rising edge of the link clock.
// - Valid qualifies data and flags; parity stands regardless of valid.
module rpf_rx_flags #(
  parameter DATA_W = 32,
  parameter CH_W   = 2
) (
  input  wire              CLK,
  input  wire              RESET_N,
  // AXI4-Lite slave
  input  wire [7:0]        S_AXI_AWADDR,
  input  wire              S_AXI_AWVALID,
  output reg               S_AXI_AWREADY,
  input  wire [31:0]       S_AXI_WDATA,
  input  wire [3:0]        S_AXI_WSTRB,
  input  wire              S_AXI_WVALID,
  output reg               S_AXI_WREADY,
  output reg  [1:0]        S_AXI_BRESP,
  output reg               S_AXI_BVALID,
  input  wire              S_AXI_BREADY,
  input  wire [7:0]        S_AXI_ARADDR,
  input  wire              S_AXI_ARVALID,
  output reg               S_AXI_ARREADY,
  output reg  [31:0]       S_AXI_RDATA,
  output reg  [1:0]        S_AXI_RRESP,
  output reg               S_AXI_RVALID,
  input  wire              S_AXI_RREADY,
  // Word source from the channel FIFO read path
  input  wire              WORD_IN_VALID,
  input  wire [DATA_W-1:0] WORD_IN_DATA,
  input  wire [2:0]        WORD_IN_BYTES,
  input  wire [CH_W-1:0]   WORD_IN_CHANNEL,
  input  wire              WORD_IN_FIRST,
  input  wire              WORD_IN_LAST,
  input  wire              WORD_IN_ABORT,
  input  wire              WORD_IN_FCS_BAD,
  input  wire              WORD_IN_OVERFLOW,
  input  wire              BUS_DRIVE_IN,
  output reg               WORD_IN_READY,
  // Link pins
  input  wire              RX_IF_CLOCK,
  input  wire              RX_READ_ENABLE,
  output reg  [DATA_W-1:0] RX_WORD_BUS,
  output reg               RX_WORD_BUS_OE,
  output reg               RX_WORD_VALID,
  output reg               RX_WORD_VALID_OE,
  output reg               RX_FRAME_FIRST_FLAG,
  output reg               RX_FRAME_FIRST_FLAG_OE,
  output reg               RX_FRAME_LAST_FLAG,
  output reg               RX_FRAME_LAST_FLAG_OE,
  output reg               RX_WORD_PARITY,
  output reg               RX_WORD_PARITY_OE,
  output reg               RX_PACKET_BAD_FLAG,
  output reg               RX_PACKET_BAD_FLAG_OE
);

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Reverse byte order so the first received byte sits in the top lane
  function [DATA_W-1:0] byte_swap;
    input [DATA_W-1:0] w;
    integer i;
    begin
      byte_swap = {DATA_W{1'b0}};
      for (i = 0; i < DATA_W / 8; i = i + 1) begin
        byte_swap[DATA_W-1-8*i -: 8] = w[8*i +: 8];
      end
    end
  endfunction

  // Merge write data under byte strobes
  function [31:0] strobe_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer k;
    begin
      strobe_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          strobe_merge[8*k +: 8] = new_v[8*k +: 8];
        end
      end
    end
  endfunction

  // ****************************************************************
  // Link pin synchronisers
  // ****************************************************************
  wire lnk_rise;
  wire rd_en_sync;

  rpf_sync_edge u_clk_sync (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .async_in (RX_IF_CLOCK),
    .level    (),
    .rise     (lnk_rise)
  );

  rpf_sync_edge u_ren_sync (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .async_in (RX_READ_ENABLE),
    .level    (rd_en_sync),
    .rise     ()
  );

  // ****************************************************************
  // Register file
  // ****************************************************************
  reg [`RPF_IF_CONFIG_W-1:0] if_config_q;
  reg [`RPF_CHANNELS-1:0]    parity_sense_q;
  reg [`RPF_LEN_W-1:0]       min_length_q;
  reg [`RPF_LEN_W-1:0]       max_length_q;
  reg [15:0]                 bad_count_q;
  reg [`RPF_LEN_W-1:0]       len_q;
  reg                        in_packet_q;
  reg [7:0]                  aw_addr_q;
  reg [31:0]                 w_data_q;
  reg [3:0]                  w_strb_q;
  reg                        aw_have_q;
  reg                        w_have_q;

  wire pos_mode     = if_config_q[`RPF_BIT_POS_MODE];
  wire test_oen     = if_config_q[`RPF_BIT_TEST_OEN];
  wire fcs_report   = if_config_q[`RPF_BIT_FCS_REPORT];
  wire short_check  = if_config_q[`RPF_BIT_SHORT_CHECK];
  wire long_check   = if_config_q[`RPF_BIT_LONG_CHECK];
  wire aw_take      = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_take       = S_AXI_WVALID & S_AXI_WREADY;
  wire wr_fire      = aw_have_q & w_have_q & ~S_AXI_BVALID;
  wire ar_take      = S_AXI_ARVALID & S_AXI_ARREADY;

  // Decode of a mapped offset, shared by reads and writes
  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `RPF_OFS_IF_CONFIG) || (a == `RPF_OFS_CHANNEL_CONFIG) ||
               (a == `RPF_OFS_MIN_LENGTH) || (a == `RPF_OFS_MAX_LENGTH) ||
               (a == `RPF_OFS_STATUS) || (a == `RPF_OFS_BAD_COUNT);
    end
  endfunction

  // Strobe-merged write words; each register keeps only its own width
  wire [31:0] cfg_merge   = strobe_merge({27'h0, if_config_q}, w_data_q, w_strb_q);
  wire [31:0] sense_merge = strobe_merge({28'h0, parity_sense_q}, w_data_q, w_strb_q);
  wire [31:0] min_merge   = strobe_merge({16'h0, min_length_q}, w_data_q, w_strb_q);
  wire [31:0] max_merge   = strobe_merge({16'h0, max_length_q}, w_data_q, w_strb_q);

  // Write channel: address and data held until both arrive
  always @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_AWREADY  <= 1'b0;
      S_AXI_WREADY   <= 1'b0;
      S_AXI_BVALID   <= 1'b0;
      S_AXI_BRESP    <= `RPF_RESP_OKAY;
      aw_have_q      <= 1'b0;
      w_have_q       <= 1'b0;
      aw_addr_q      <= 8'h00;
      w_data_q       <= 32'h0000_0000;
      w_strb_q       <= 4'h0;
      if_config_q    <= `RPF_RST_IF_CONFIG;
      parity_sense_q <= `RPF_RST_CHANNEL_CONFIG;
      min_length_q   <= `RPF_RST_MIN_LENGTH;
      max_length_q   <= `RPF_RST_MAX_LENGTH;
    end else begin
      S_AXI_AWREADY <= ~aw_have_q & ~aw_take;
      S_AXI_WREADY  <= ~w_have_q & ~w_take;
      if (aw_take) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= mapped(aw_addr_q) ? `RPF_RESP_OKAY : `RPF_RESP_SLVERR;
        case (aw_addr_q)
          `RPF_OFS_IF_CONFIG: begin
            if_config_q <= cfg_merge[`RPF_IF_CONFIG_W-1:0];
          end
          `RPF_OFS_CHANNEL_CONFIG: begin
            parity_sense_q <= sense_merge[`RPF_CHANNELS-1:0];
          end
          `RPF_OFS_MIN_LENGTH: begin
            min_length_q <= min_merge[`RPF_LEN_W-1:0];
          end
          `RPF_OFS_MAX_LENGTH: begin
            max_length_q <= max_merge[`RPF_LEN_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read channel: one read at a time, status reflects live packet state
  always @(posedge CLK) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `RPF_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take & ~S_AXI_ARREADY;
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
      if (ar_take) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ? `RPF_RESP_OKAY : `RPF_RESP_SLVERR;
        case (S_AXI_ARADDR)
          `RPF_OFS_IF_CONFIG:      S_AXI_RDATA <= {27'h0, if_config_q};
          `RPF_OFS_CHANNEL_CONFIG: S_AXI_RDATA <= {28'h0, parity_sense_q};
          `RPF_OFS_MIN_LENGTH:     S_AXI_RDATA <= {16'h0, min_length_q};
          `RPF_OFS_MAX_LENGTH:     S_AXI_RDATA <= {16'h0, max_length_q};
          `RPF_OFS_STATUS:         S_AXI_RDATA <= {15'h0, in_packet_q, len_q};
          `RPF_OFS_BAD_COUNT:      S_AXI_RDATA <= {16'h0, bad_count_q};
          default:                 S_AXI_RDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Word path and flag generation
  // ****************************************************************
  reg  [`RPF_LEN_W-1:0] len_d;
  reg                   bad_d;
  wire                  take = lnk_rise & rd_en_sync & WORD_IN_VALID;
  wire [DATA_W-1:0]     out_data = byte_swap(WORD_IN_DATA);
  wire                  last_oe = pos_mode | test_oen;

  // Running byte count of the packet, and the error verdict on its last word
  always @* begin
    len_d = (WORD_IN_FIRST ? {`RPF_LEN_W{1'b0}} : len_q) +
            {{(`RPF_LEN_W-3){1'b0}}, (WORD_IN_LAST ? WORD_IN_BYTES : `RPF_BYTES_PER_WORD)};
    bad_d = WORD_IN_LAST & pos_mode &
            (WORD_IN_ABORT |
             (WORD_IN_FCS_BAD & fcs_report) |
             (short_check & (len_d < min_length_q)) |
             (long_check & (len_d > max_length_q)) |
             WORD_IN_OVERFLOW);
  end

  // Link pin outputs move only on a sampled link clock rising edge; WORD_IN_READY pulses for one cycle per taken word
  always @(posedge CLK) begin
    if (!RESET_N) begin
      RX_WORD_BUS            <= {DATA_W{1'b0}};
      RX_WORD_VALID          <= 1'b0;
      RX_FRAME_FIRST_FLAG    <= 1'b0;
      RX_FRAME_LAST_FLAG     <= 1'b0;
      RX_PACKET_BAD_FLAG     <= 1'b0;
      RX_WORD_PARITY         <= 1'b0;
      RX_WORD_BUS_OE         <= 1'b0;
      RX_WORD_VALID_OE       <= 1'b0;
      RX_FRAME_FIRST_FLAG_OE <= 1'b0;
      RX_FRAME_LAST_FLAG_OE  <= 1'b0;
      RX_WORD_PARITY_OE      <= 1'b0;
      RX_PACKET_BAD_FLAG_OE  <= 1'b0;
      WORD_IN_READY          <= 1'b0;
      len_q                  <= {`RPF_LEN_W{1'b0}};
      in_packet_q            <= 1'b0;
      bad_count_q            <= 16'h0000;
    end else begin
      WORD_IN_READY <= take;
      if (lnk_rise) begin
        // Start and parity flags share the data bus enable; valid enable is also gated by mode, end and error enables by mode or test enable
        RX_WORD_BUS_OE         <= BUS_DRIVE_IN;
        RX_WORD_VALID_OE       <= BUS_DRIVE_IN & pos_mode;
        RX_FRAME_FIRST_FLAG_OE <= BUS_DRIVE_IN;
        RX_WORD_PARITY_OE      <= BUS_DRIVE_IN;
        RX_FRAME_LAST_FLAG_OE  <= BUS_DRIVE_IN & last_oe;
        RX_PACKET_BAD_FLAG_OE  <= BUS_DRIVE_IN & last_oe;
        RX_WORD_VALID          <= take;
        if (take) begin
          RX_WORD_BUS         <= out_data;
          // Parity follows the bus word even while valid is low
          RX_WORD_PARITY      <= ^out_data ^ parity_sense_q[WORD_IN_CHANNEL];
          RX_FRAME_FIRST_FLAG <= WORD_IN_FIRST;
          RX_FRAME_LAST_FLAG  <= WORD_IN_LAST & pos_mode;
          RX_PACKET_BAD_FLAG  <= bad_d;
          len_q               <= WORD_IN_LAST ? {`RPF_LEN_W{1'b0}} : len_d;
          in_packet_q         <= ~WORD_IN_LAST;
          if (bad_d) begin
            bad_count_q <= bad_count_q + 16'h0001;
          end
        end else begin
          // Stale word kept so parity stays consistent with the bus
          RX_FRAME_FIRST_FLAG <= 1'b0;
          RX_FRAME_LAST_FLAG  <= 1'b0;
          RX_PACKET_BAD_FLAG  <= 1'b0;
        end
      end
    end
  end

endmodule

// ---- verification/rpf_rx_flags_assertions.sv ----
// Checker for the receive flag block: word marking, lane order,
// driver enables and link-edge timing, seen at the block's ports.
// Assumes it is bound into rpf_rx_flags with its data width.
`timescale 1ns/1ps

module rpf_rx_flags_assertions #(
  parameter DATA_W = 32
) (
  input wire              CLK,
  input wire              RESET_N,
  input wire [DATA_W-1:0] WORD_IN_DATA,
  input wire              WORD_IN_FIRST,
  input wire              WORD_IN_READY,
  input wire              RX_IF_CLOCK,
  input wire [DATA_W-1:0] RX_WORD_BUS,
  input wire              RX_WORD_BUS_OE,
  input wire              RX_WORD_VALID,
  input wire              RX_WORD_VALID_OE,
  input wire              RX_FRAME_FIRST_FLAG,
  input wire              RX_FRAME_FIRST_FLAG_OE,
  input wire              RX_FRAME_LAST_FLAG,
  input wire              RX_FRAME_LAST_FLAG_OE,
  input wire              RX_WORD_PARITY_OE,
  input wire              RX_PACKET_BAD_FLAG,
  input wire              RX_PACKET_BAD_FLAG_OE
);
  // ********
  // Helpers
  // ********
  // Window wide enough for the two or three flop synchroniser slack
  reg  [4:0]        lk_q;
  wire              lk_recent = |(lk_q[3:0] & ~lk_q[4:1]);
  wire [DATA_W-1:0] in_rev    = {<<8{WORD_IN_DATA}};
  always @(posedge CLK)
    lk_q <= {lk_q[3:0], RX_IF_CLOCK};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  property p_one_word;
    WORD_IN_READY |=> !WORD_IN_READY [*4];
  endproperty
  a_one_word: assert property (p_one_word) else $error("two words in one link period");
  property p_link_edge;
    ($changed(RX_WORD_BUS) || $changed(RX_WORD_VALID)) |-> $past(lk_recent);
  endproperty
  a_link_edge: assert property (p_link_edge) else $error("output moved without a link rise");
  property p_lane;
    WORD_IN_READY |-> RX_WORD_VALID && RX_WORD_BUS == $past(in_rev);
  endproperty
  a_lane: assert property (p_lane) else $error("word bytes on wrong lanes");
  property p_first;
    WORD_IN_READY |-> RX_FRAME_FIRST_FLAG == $past(WORD_IN_FIRST);
  endproperty
  a_first: assert property (p_first) else $error("start flag differs from word");
  property p_bad_last;
    RX_PACKET_BAD_FLAG |-> RX_FRAME_LAST_FLAG && RX_WORD_VALID;
  endproperty
  a_bad_last: assert property (p_bad_last) else $error("error flag off the last word");
  property p_qualified;
    RX_FRAME_FIRST_FLAG |-> RX_WORD_VALID;
  endproperty
  a_qualified: assert property (p_qualified) else $error("start flag without valid");
  property p_oe_same;
    RX_FRAME_FIRST_FLAG_OE == RX_WORD_BUS_OE && RX_WORD_PARITY_OE == RX_WORD_BUS_OE;
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("flag enable differs from bus");
  property p_oe_pkt;
    RX_PACKET_BAD_FLAG_OE == RX_FRAME_LAST_FLAG_OE && (RX_FRAME_LAST_FLAG_OE -> RX_WORD_BUS_OE);
  endproperty
  a_oe_pkt: assert property (p_oe_pkt) else $error("end or error enable wrong");

  c_bad: cover property (RX_PACKET_BAD_FLAG);
  c_single: cover property (WORD_IN_READY && RX_FRAME_FIRST_FLAG && RX_FRAME_LAST_FLAG);
  c_test_oe: cover property (RX_FRAME_LAST_FLAG_OE && !RX_WORD_VALID_OE);
endmodule

bind rpf_rx_flags rpf_rx_flags_assertions #(.DATA_W(DATA_W)) u_rpf_rx_flags_assertions (.*);

// ---- verification/rpf_link_partner.sv ----
// Link-side reader model: makes the link clock, holds read enable and
// throws away packets whose last word carries the error flag.
// Assumes the flag block samples the link clock with its own clock.
`timescale 1ns/1ps

module rpf_link_partner (
  input  wire  run,
  input  wire  word_valid,
  input  wire  valid_oe,
  input  wire  last_flag,
  input  wire  bad_flag,
  output logic link_clk,
  output wire  read_en,
  output int   n_dropped = 0
);
  // Link clock runs free as on a cell bus; phase unrelated to CLK
  initial begin
    link_clk = 1'b0;
    #37;
    forever #200 link_clk = ~link_clk;
  end
  // Reading goes on while the bench allows it
  assign read_en = run;
  // Only a driven, valid last word counts; a bad one is discarded
  always @(posedge link_clk)
    if (valid_oe === 1'b1 && word_valid === 1'b1 && last_flag === 1'b1 && bad_flag === 1'b1)
      n_dropped <= n_dropped + 1;
endmodule

// ---- verification/tb_rpf_rx_flags.sv ----
// Bench for the receive flag block: register tasks over AXI4-Lite,
// a word source task and packet scenarios with expected flags.
// Assumes rpf_link_partner supplies link clock and read enable.
`timescale 1ns/1ps

module tb_rpf_rx_flags;
  logic        clk, reset_n, awvalid, wvalid, bready, arvalid, rready, run, drive;
  logic        in_valid, in_first, in_last, in_abort, in_fcs, in_ovf;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, in_data;
  logic [3:0]  wstrb, sense;
  logic [2:0]  in_bytes;
  logic [1:0]  in_ch;
  logic [4:0]  cfg;
  logic [15:0] len, min_len, max_len;
  wire         awready, wready, bvalid, arready, rvalid, in_ready, link_clk, read_en;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata, bus;
  wire         bus_oe, val, val_oe, first, first_oe, last, last_oe, par, par_oe, bad, bad_oe;
  int          n_errors = 0;
  int          n_tests = 0;
  int          exp_bad = 0;
  int          n_dropped;

  rpf_rx_flags u_rpf_rx_flags (
    .CLK(clk), .RESET_N(reset_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .WORD_IN_VALID(in_valid), .WORD_IN_DATA(in_data),
    .WORD_IN_BYTES(in_bytes), .WORD_IN_CHANNEL(in_ch), .WORD_IN_FIRST(in_first), .WORD_IN_LAST(in_last),
    .WORD_IN_ABORT(in_abort), .WORD_IN_FCS_BAD(in_fcs), .WORD_IN_OVERFLOW(in_ovf), .BUS_DRIVE_IN(drive),
    .WORD_IN_READY(in_ready), .RX_IF_CLOCK(link_clk), .RX_READ_ENABLE(read_en), .RX_WORD_BUS(bus),
    .RX_WORD_BUS_OE(bus_oe), .RX_WORD_VALID(val), .RX_WORD_VALID_OE(val_oe), .RX_FRAME_FIRST_FLAG(first),
    .RX_FRAME_FIRST_FLAG_OE(first_oe), .RX_FRAME_LAST_FLAG(last), .RX_FRAME_LAST_FLAG_OE(last_oe),
    .RX_WORD_PARITY(par), .RX_WORD_PARITY_OE(par_oe), .RX_PACKET_BAD_FLAG(bad), .RX_PACKET_BAD_FLAG_OE(bad_oe));

  rpf_link_partner u_rpf_link_partner (
    .run(run), .word_valid(val), .valid_oe(val_oe), .last_flag(last), .bad_flag(bad),
    .link_clk(link_clk), .read_en(read_en), .n_dropped(n_dropped));

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, er);
    // Let an edge pass so a following call never re-drives bready in this step
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk(rresp, er);
    @(posedge clk);
  endtask

  // Upper bits written as ones must read back as zero
  task automatic setcfg(input logic [4:0] v);
    axi_wr(8'h00, {27'h7ffffff, v}, 2'b00);
    axi_rd(8'h00, {27'h0, v}, 2'b00);
    cfg = v;
  endtask

  // One word; err is abort, check-sequence error, overflow
  task automatic send(input logic [31:0] d, input logic [2:0] nb, input logic [1:0] ch,
                      input logic f, input logic l, input logic [2:0] err);
    logic eb;
    {in_data, in_bytes, in_ch, in_first, in_last, in_abort, in_fcs, in_ovf, in_valid} <= {d, nb, ch, f, l, err, 1'b1};
    len = (f ? 16'h0 : len) + (l ? {13'h0, nb} : 16'h4);
    eb = l & cfg[0] & (err[2] | err[1] & cfg[2] | (len < min_len) & cfg[3] | (len > max_len) & cfg[4] | err[0]);
    exp_bad += eb;
    do @(negedge clk); while (in_ready !== 1'b1);
    chk(bus, {d[7:0], d[15:8], d[23:16], d[31:24]});
    chk({val, first, last, bad}, {1'b1, f, l & cfg[0], eb});
    chk(par, ^d ^ sense[ch]);
    chk({bus_oe, first_oe, par_oe}, {3{drive}});
    chk({last_oe, bad_oe}, {2{drive & (cfg[0] | cfg[1])}});
    chk(val_oe, drive & cfg[0]);
    @(posedge clk);
  endtask

  task automatic pkt(input int nw, input logic [2:0] nb, input logic [1:0] ch, input logic [2:0] err);
    for (int i = 0; i < nw; i++)
      send(32'h04030201 + 32'h04040404 * i, (i == nw - 1) ? nb : 3'h4, ch, i == 0, i == nw - 1,
           (i == nw - 1) ? err : 3'b000);
    in_valid <= 1'b0;
    // More than one link period with no word: valid and flags must drop
    repeat (10) @(posedge clk);
    chk({val, first, last, bad}, 4'h0);
  endtask

  task test_done;
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, far above the expected run of some 30 us
  initial begin
    #2000000;
    n_errors++;
    test_done;
  end

  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, in_valid, run} = '0;
    {awaddr, araddr, wdata, in_data, in_bytes, in_ch, in_first, in_last, in_abort, in_fcs, in_ovf} = '0;
    {wstrb, drive, cfg, sense, min_len, max_len, len} = {4'hf, 1'b1, 5'h01, 4'h0, 16'h0, 16'hffff, 16'h0};
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    axi_rd(8'h00, 32'h1, 2'b00);
    axi_rd(8'h08, 32'h0, 2'b00);
    axi_rd(8'h0c, 32'hffff, 2'b00);
    axi_rd(8'h18, 32'h0, 2'b10);
    axi_wr(8'h18, 32'hffffffff, 2'b10);
    axi_wr(8'h04, 32'h5, 2'b00);
    sense = 4'h5;
    run <= 1'b1;
    repeat (20) @(posedge clk);
    pkt(3, 3'h4, 2'd0, 3'b000);
    pkt(1, 3'h2, 2'd2, 3'b000);
    pkt(2, 3'h3, 2'd1, 3'b100);
    pkt(2, 3'h3, 2'd3, 3'b010);
    setcfg(5'h05);
    pkt(2, 3'h3, 2'd3, 3'b010);
    pkt(2, 3'h1, 2'd0, 3'b001);
    axi_wr(8'h08, 32'd10, 2'b00);
    axi_wr(8'h0c, 32'd12, 2'b00);
    {min_len, max_len} = {16'd10, 16'd12};
    setcfg(5'h19);
    pkt(2, 3'h1, 2'd1, 3'b000);
    pkt(3, 3'h2, 2'd1, 3'b000);
    pkt(3, 3'h4, 2'd2, 3'b000);
    pkt(4, 3'h1, 2'd2, 3'b000);
    setcfg(5'h00);
    pkt(2, 3'h4, 2'd0, 3'b100);
    setcfg(5'h02);
    pkt(1, 3'h4, 2'd3, 3'b000);
    drive <= 1'b0;
    pkt(1, 3'h4, 2'd2, 3'b000);
    drive <= 1'b1;
    setcfg(5'h01);
    axi_wr(8'h14, 32'h0, 2'b00);
    axi_rd(8'h14, exp_bad, 2'b00);
    axi_rd(8'h10, 32'h0, 2'b00);
    repeat (20) @(posedge clk);
    chk(n_dropped, exp_bad);
    test_done;
  end
endmodule
